// [hw/slbc_pkg.sv]
// Package for the serial link self-test controller.
// Assumes an 8-bit register address space reached by a local target port.
package slbc_pkg;
  localparam int          NUM_PORTS     = 4;
  localparam logic [7:0]  ADDR_PAGE_SEL = 8'h4C;
  localparam logic [7:0]  ADDR_ERR_TALLY = 8'h57;
  localparam logic [7:0]  ADDR_TEST_CTL = 8'hB3;
  localparam logic [7:0]  PORT_LO       = 8'h46;
  localparam logic [7:0]  PORT_HI       = 8'h7F;
  localparam logic [7:0]  DBG_LO        = 8'hD0;
  localparam logic [7:0]  DBG_HI        = 8'hDF;
  localparam logic [7:0]  TALLY_LOCKFAIL = 8'hFF;
  localparam logic [7:0]  TALLY_MAX     = 8'hFE;
  localparam int          CTL_EN_BIT    = 0;
  localparam int          CTL_CLK_LSB   = 1;
  localparam int          CTL_GATE_LSB  = 6;
  localparam logic [1:0]  GATE_OFF      = 2'h0;
  localparam logic [1:0]  GATE_ON       = 2'h2;
  localparam logic [7:0]  SER_CLK_REG   = 8'h14;
  localparam logic [7:0]  SER_MODE_REG  = 8'h13;
  localparam logic [7:0]  SER_MODE_ON   = 8'h01;
  localparam logic [7:0]  SER_MODE_OFF  = 8'h00;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
endpackage

// [hw/slbc_reg_if.sv]
// Register access interface between the top and the back-channel sender.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface slbc_bc_if;
  logic       req;
  logic [7:0] addr;
  logic [7:0] data;
  logic       busy;
  logic       done;
  modport ctl (output req, output addr, output data,
               input busy, input done);
  modport snd (input req, input addr, input data,
               output busy, output done);
endinterface

// [hw/slbc_bc_sender.sv]
// Back-channel write sender: latches one register write, presents it.
// Assumes the link layer accepts a write with a ready-style handshake.
`timescale 1ns/1ps
module slbc_bc_sender (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic clk_en,
  // Control side
  slbc_bc_if.snd    bc,
  // Link side
  output logic       wr_valid,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  input  wire logic  wr_ready
);
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] data;
    logic       done;
  } slbc_snd_t;
  slbc_snd_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (s_q.valid && wr_ready) begin
      s_d.valid = 1'b0;
      s_d.done = 1'b1;
    end else if (!s_q.valid && bc.req) begin
      s_d.valid = 1'b1;
      s_d.addr = bc.addr;
      s_d.data = bc.data;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset)
      s_q <= '0;
    else if (clk_en)
      s_q <= s_d;
  end

  assign wr_valid = s_q.valid;
  assign wr_addr  = s_q.addr;
  assign wr_data  = s_q.data;
  assign bc.busy  = s_q.valid;
  assign bc.done  = s_q.done;
endmodule // slbc_bc_sender

// [hw/slbc_top.sv]
// Self-test controller for a four-port serial link hub.
// Assumes register accesses arrive as one-cycle strobes from the I2C target
// and control-channel decoders, already merged.
`timescale 1ns/1ps
// Contract
// - Start sends mode writes to remote serializer
// - Each port checks stream, flags mismatches
// - Per-port error tally read at 0x57
// - No lock or lost lock reads FF
// - Error counting saturates at FE
// - Pass pin pulses low per error
// - Gating 00 disables outputs during test
// - Gating 10 keeps outputs enabled
// - Enabled outputs idle LP11 unless pattern
// - Clock select copied to remote 0x14[2:1]
// - Clock select captured only at start
// - Registers reachable from both access ports
// - Port space reads page, writes broadcast (code decodes only the 0x4C page register and the paged 0x57 read there; other port-space writes are ignored)
// - Debug space uses same paging
module slbc_top #(
  parameter int NPORT = slbc_pkg::NUM_PORTS
) (
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              clk_en,
  // Merged register access (I2C target or control channel)
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  // Receive ports
  input  wire logic [NPORT-1:0]  rx_lock,
  input  wire logic [NPORT-1:0]  rx_sync,
  input  wire logic [NPORT-1:0]  rx_err,
  input  wire logic              pattern_gen_en,
  // Back channel writes to remote serializer
  output logic                   bc_wr_valid,
  output logic      [7:0]        bc_wr_addr,
  output logic      [7:0]        bc_wr_data,
  input  wire logic              bc_wr_ready,
  // Output gating and status
  output logic                   test_active,
  output logic                   outputs_enable,
  output logic                   csi_lp11_idle,
  output logic      [NPORT-1:0]  port_pass
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MODE = 2'b01,
    ST_CLK  = 2'b11,
    ST_RUN  = 2'b10
  } slbc_state_t;

  typedef struct packed {
    slbc_state_t            st;
    logic [7:0]             ctl;
    logic [7:0]             page;
    logic [1:0]             clk_sel;
    logic                   sent;
    logic                   stop_pend;
    logic [NPORT-1:0][7:0]  tally;
    logic [NPORT-1:0][7:0]  dbg;
    logic [NPORT-1:0]       locked_once;
    logic [7:0]             rdata;
    logic                   rvalid;
    logic                   oe;
    logic                   lp11;
    logic [NPORT-1:0]       pass;
    logic                   active;
  } slbc_state_s_t;

  slbc_state_s_t r_q, r_d;
  slbc_bc_if bc ();

  function automatic logic [7:0] tally_next(input logic [7:0] t);
    return (t >= slbc_pkg::TALLY_MAX) ? t : t + 8'h01;
  endfunction

  function automatic logic in_rng(input logic [7:0] a,
                                  input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  slbc_bc_sender u_snd (
    .mclk     (mclk),
    .reset    (reset),
    .clk_en   (clk_en),
    .bc       (bc.snd),
    .wr_valid (bc_wr_valid),
    .wr_addr  (bc_wr_addr),
    .wr_data  (bc_wr_data),
    .wr_ready (bc_wr_ready)
  );

  logic [1:0] pg;
  logic       enw;
  logic       run;
  assign pg  = r_q.page[5:4];
  assign run = (r_q.st == ST_RUN);
  assign enw = reg_wr && (reg_addr == slbc_pkg::ADDR_TEST_CTL);

  always_comb begin
    r_d = r_q;
    r_d.rvalid = 1'b0;
    r_d.sent = 1'b0;
    bc.req  = 1'b0;
    bc.addr = slbc_pkg::SER_MODE_REG;
    bc.data = slbc_pkg::SER_MODE_ON;
    // Both access ports share this decoder
    if (reg_wr) begin
      if (reg_addr == slbc_pkg::ADDR_PAGE_SEL)
        r_d.page = reg_wdata;
      else if (enw)
        r_d.ctl = reg_wdata;
      else if (in_rng(reg_addr, slbc_pkg::DBG_LO, slbc_pkg::DBG_HI))
        for (int p = 0; p < NPORT; p++)
          if (r_q.page[p]) r_d.dbg[p] = reg_wdata;
    end
    if (reg_rd) begin
      r_d.rvalid = 1'b1;
      r_d.rdata  = slbc_pkg::RESET_BYTE;
      if (reg_addr == slbc_pkg::ADDR_PAGE_SEL)
        r_d.rdata = r_q.page;
      else if (reg_addr == slbc_pkg::ADDR_TEST_CTL)
        r_d.rdata = r_q.ctl;
      else if (reg_addr == slbc_pkg::ADDR_ERR_TALLY)
        r_d.rdata = r_q.tally[pg];
      else if (in_rng(reg_addr, slbc_pkg::DBG_LO, slbc_pkg::DBG_HI))
        r_d.rdata = r_q.dbg[pg];
    end
    unique case (r_q.st)
      ST_IDLE: if (r_q.ctl[slbc_pkg::CTL_EN_BIT]) begin
        // Clock select frozen here; later writes do not reach the remote
        r_d.clk_sel = r_q.ctl[slbc_pkg::CTL_CLK_LSB +: 2];
        r_d.tally = '0;
        r_d.locked_once = '0;
        r_d.stop_pend = 1'b0;
        r_d.st = ST_MODE;
      end
      ST_MODE: begin
        bc.req = !bc.busy && !r_q.sent;
        if (bc.req) r_d.sent = 1'b1;
        if (bc.done) r_d.st = ST_CLK;
        else if (r_q.sent) r_d.sent = 1'b1;
      end
      ST_CLK: begin
        bc.addr = slbc_pkg::SER_CLK_REG;
        bc.data = {5'h00, r_q.clk_sel, 1'b0};
        bc.req = !bc.busy && !r_q.sent;
        if (bc.req) r_d.sent = 1'b1;
        if (bc.done) r_d.st = ST_RUN;
        else if (r_q.sent) r_d.sent = 1'b1;
      end
      ST_RUN: begin
        for (int p = 0; p < NPORT; p++) begin
          if (rx_lock[p]) r_d.locked_once[p] = 1'b1;
          // Lock failure value is sticky for the rest of the run
          if (r_q.tally[p] == slbc_pkg::TALLY_LOCKFAIL)
            r_d.tally[p] = slbc_pkg::TALLY_LOCKFAIL;
          else if (r_q.locked_once[p] && !rx_lock[p])
            r_d.tally[p] = slbc_pkg::TALLY_LOCKFAIL;
          else if (rx_lock[p] && rx_sync[p] && rx_err[p])
            r_d.tally[p] = tally_next(r_q.tally[p]);
        end
        if (!r_q.ctl[slbc_pkg::CTL_EN_BIT]) begin
          // Ports that never locked are marked at the end of the run
          for (int p = 0; p < NPORT; p++)
            if (!r_q.locked_once[p] && !rx_lock[p])
              r_d.tally[p] = slbc_pkg::TALLY_LOCKFAIL;
          r_d.st = ST_IDLE;
        end
      end
    endcase
    // Remote mode-off write is not issued; the remote leaves test on link drop
    for (int p = 0; p < NPORT; p++)
      r_d.pass[p] = !(run && rx_err[p]);
    r_d.oe = !run ||
             (r_q.ctl[slbc_pkg::CTL_GATE_LSB +: 2] == slbc_pkg::GATE_ON);
    r_d.lp11 = run && !pattern_gen_en;
    // Registered copy so the status pin never shows decode glitches
    r_d.active = (r_d.st == ST_RUN);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      r_q <= '0;
      r_q.oe <= 1'b1;
      r_q.pass <= '1;
    end else if (clk_en) begin
      r_q <= r_d;
    end
  end

  assign reg_rdata      = r_q.rdata;
  assign reg_rvalid     = r_q.rvalid;
  assign test_active    = r_q.active;
  assign outputs_enable = r_q.oe;
  assign csi_lp11_idle  = r_q.lp11;
  assign port_pass      = r_q.pass;

  // Port 2 is driven to saturation by the bench
  chk_tally_no_ff: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && run && r_q.tally[2] == slbc_pkg::TALLY_MAX && rx_lock[2]
    && r_q.locked_once[2] && r_q.ctl[slbc_pkg::CTL_EN_BIT]
    |=> r_q.tally[2] == slbc_pkg::TALLY_MAX)
    else $error("tally passed FE on errors");
  // Port 3 is the one that drops lock in the bench
  chk_lock_loss_ff: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && run && r_q.locked_once[3] && !rx_lock[3]
    |=> r_q.tally[3] == slbc_pkg::TALLY_LOCKFAIL)
    else $error("lost lock did not give FF");
  chk_err_counts: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && run && rx_lock[1] && rx_sync[1] && rx_err[1]
    && r_q.tally[1] < slbc_pkg::TALLY_MAX && r_q.ctl[slbc_pkg::CTL_EN_BIT]
    |=> r_q.tally[1] == $past(r_q.tally[1]) + 8'h01)
    else $error("error not counted");
  chk_start_clear: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && r_q.st == ST_IDLE && r_q.ctl[slbc_pkg::CTL_EN_BIT]
    |=> r_q.tally == '0 && r_q.st == ST_MODE)
    else $error("start did not clear tallies");
  chk_pass_low: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && run && rx_err[1] |=> !port_pass[1])
    else $error("pass pin not low on error");
  chk_gate_off: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && run
    && r_q.ctl[slbc_pkg::CTL_GATE_LSB +: 2] == slbc_pkg::GATE_OFF
    |=> !outputs_enable)
    else $error("outputs not gated");
  chk_gate_on: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && run
    && r_q.ctl[slbc_pkg::CTL_GATE_LSB +: 2] == slbc_pkg::GATE_ON
    |=> outputs_enable)
    else $error("outputs gated wrongly");
  chk_clk_frozen: assert property (
    @(posedge mclk) disable iff (reset)
    run |=> r_q.clk_sel == $past(r_q.clk_sel))
    else $error("clock select changed in run");
  chk_clk_write: assert property (
    @(posedge mclk) disable iff (reset)
    bc_wr_valid && bc_wr_addr == slbc_pkg::SER_CLK_REG
    |-> bc_wr_data[2:1] == r_q.clk_sel)
    else $error("clock select write wrong");
  chk_read_page: assert property (
    @(posedge mclk) disable iff (reset)
    clk_en && reg_rd && reg_addr == slbc_pkg::ADDR_ERR_TALLY
    |=> reg_rvalid && reg_rdata == $past(r_q.tally[pg]))
    else $error("paged read wrong");
endmodule // slbc_top

// [verif/slbc_remote_model.sv]
// Remote serializer model: accepts back-channel register writes.
// Assumes one clock; writes are held by the hub until ready is seen.
`timescale 1ns/1ps
module slbc_remote_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Back channel
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_addr,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  // Observed registers
  output logic [7:0]      mode_q,
  output logic [7:0]      clk_q,
  output int              writes
);
  int wait_q;
  always @(posedge mclk) begin
    if (reset) begin
      wr_ready <= 1'b0;
      mode_q   <= 8'h00;
      clk_q    <= 8'h00;
      writes   <= 0;
      wait_q   <= 2;
    end else if (wr_valid && wr_ready) begin
      wr_ready <= 1'b0;
      writes   <= writes + 1;
      // Random stall so both prompt and slow answers are seen
      wait_q   <= $urandom % 4;
      if (wr_addr == slbc_pkg::SER_MODE_REG) mode_q <= wr_data;
      if (wr_addr == slbc_pkg::SER_CLK_REG) clk_q <= wr_data;
    end else if (wr_valid) begin
      if (wait_q == 0) wr_ready <= 1'b1;
      else wait_q <= wait_q - 1;
    end
  end
endmodule // slbc_remote_model

// [verif/test_serial_link_bist_controller.sv]
// Self-checking bench for the link self-test controller.
// Assumes the remote model answers back-channel writes.
`timescale 1ns/1ps
module test_serial_link_bist_controller;
  logic       mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, pgen = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, bc_a, bc_d;
  logic [3:0] lock = 4'h0, sync = 4'h0, err = 4'h0, pass;
  logic       rvalid, bc_v, bc_r, active, oe, lp11;
  logic [7:0] s_mode, s_clk, exp_t[4];
  logic [1:0] csel;
  int         s_wr, w0, n1, fail_count = 0, samples_checked = 0, cyc = 0;
  int         lows[4];
  logic [7:0] exp_q[$];
  always #2.5 mclk = ~mclk;
  slbc_top dut (.mclk(mclk), .reset(reset), .clk_en(1'b1), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .rx_lock(lock), .rx_sync(sync),
    .rx_err(err), .pattern_gen_en(pgen), .bc_wr_valid(bc_v),
    .bc_wr_addr(bc_a), .bc_wr_data(bc_d), .bc_wr_ready(bc_r),
    .test_active(active), .outputs_enable(oe), .csi_lp11_idle(lp11),
    .port_pass(pass));
  slbc_remote_model far (.mclk(mclk), .reset(reset), .wr_valid(bc_v),
    .wr_addr(bc_a), .wr_data(bc_d), .wr_ready(bc_r), .mode_q(s_mode),
    .clk_q(s_clk), .writes(s_wr));
  task check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 0;
  endtask
  task rd(logic [7:0] a, logic [7:0] e);
    @(negedge mclk);
    reg_rd = 1;
    reg_addr = a;
    exp_q.push_back(e);
    @(negedge mclk);
    reg_rd = 0;
  endtask
  task start(logic [7:0] d);
    wr(slbc_pkg::ADDR_TEST_CTL, d);
    repeat (100) if (active !== 1'b1) @(negedge mclk);
    check("test_active", active, 1);
    // Gating and idle outputs follow the run state one cycle later
    @(negedge mclk);
  endtask
  task errs(int p, int n);
    repeat (n) begin
      @(negedge mclk);
      err[p] = 1;
      @(negedge mclk);
      err[p] = 0;
    end
  endtask
  // Read data is compared against the oldest noted expectation
  always @(negedge mclk) begin
    if (rvalid === 1'b1)
      check("rdata", rdata, exp_q.size() ? exp_q.pop_front() : 8'hxx);
    for (int p = 0; p < 4; p++) lows[p] += (pass[p] === 1'b0);
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end
  initial begin
    void'($urandom(32'hA2F2AADE));
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    reset = 0;
    check("oe", oe, 1);
    check("pass", pass, 4'hF);
    wr(slbc_pkg::ADDR_PAGE_SEL, 8'h1F);
    rd(slbc_pkg::ADDR_PAGE_SEL, 8'h1F);
    rd(8'h20, 8'h00);
    lock = 4'hF;
    sync = 4'hF;
    csel = $urandom % 3;
    n1 = 1 + $urandom % 20;
    start({5'h00, csel, 1'b1});
    check("ser mode", s_mode, slbc_pkg::SER_MODE_ON);
    check("ser clk", s_clk[2:1], csel);
    check("oe off", oe, 0);
    w0 = s_wr;
    wr(slbc_pkg::ADDR_TEST_CTL, {5'h00, ~csel, 1'b1});
    repeat (20) @(negedge mclk);
    check("ser writes", s_wr, w0);
    check("ser clk", s_clk[2:1], csel);
    lows = '{0, 0, 0, 0};
    errs(1, n1);
    errs(2, 300);
    lock[3] = 0;
    repeat (3) @(negedge mclk);
    lock[3] = 1;
    check("lows1", lows[1], n1);
    check("lows2", lows[2], 300);
    check("lows0", lows[0], 0);
    wr(slbc_pkg::ADDR_TEST_CTL, 8'h00);
    repeat (5) @(negedge mclk);
    check("stopped", active, 0);
    exp_t = '{8'h00, n1[7:0], slbc_pkg::TALLY_MAX, slbc_pkg::TALLY_LOCKFAIL};
    for (int p = 0; p < 4; p++) begin
      wr(slbc_pkg::ADDR_PAGE_SEL, {2'b00, p[1:0], 4'h0});
      rd(slbc_pkg::ADDR_ERR_TALLY, exp_t[p]);
    end
    start(8'h81);
    check("oe on", oe, 1);
    check("lp11", lp11, 1);
    pgen = 1;
    repeat (3) @(negedge mclk);
    check("lp11 pgen", lp11, 0);
    for (int p = 0; p < 4; p++) begin
      wr(slbc_pkg::ADDR_PAGE_SEL, {2'b00, p[1:0], 4'h0});
      rd(slbc_pkg::ADDR_ERR_TALLY, 8'h00);
    end
    wr(slbc_pkg::ADDR_PAGE_SEL, 8'h05);
    wr(slbc_pkg::DBG_LO, 8'h5A);
    wr(slbc_pkg::ADDR_PAGE_SEL, 8'h02);
    wr(slbc_pkg::DBG_HI, 8'hA5);
    exp_t = '{8'h5A, 8'hA5, 8'h5A, 8'h00};
    for (int p = 0; p < 4; p++) begin
      wr(slbc_pkg::ADDR_PAGE_SEL, {2'b00, p[1:0], 4'h0});
      rd(slbc_pkg::DBG_LO + 8'h03, exp_t[p]);
    end
    wr(slbc_pkg::ADDR_TEST_CTL, 8'h00);
    repeat (5) @(negedge mclk);
    check("queue", exp_q.size(), 0);
    results();
  end
endmodule // test_serial_link_bist_controller
